// *** src/dbs_defines.svh ***
// timing counts, packet field positions and command codes of the bank-set link
`ifndef DBS_DEFINES_SVH
`define DBS_DEFINES_SVH
// request packet layout on the request bus pins
`define DBS_REQ_W 12
`define DBS_OP_HI 11
`define DBS_OP_LO 9
`define DBS_BANK_HI 8
`define DBS_BANK_LO 6
`define DBS_DATA_HI 5
`define DBS_DATA_LO 0
// command codes
`define DBS_OP_NOP 3'h0
`define DBS_OP_ACT 3'h1
`define DBS_OP_PRE 3'h2
`define DBS_OP_WR 3'h3
`define DBS_OP_RD 3'h4
`define DBS_OP_PRE_PAIR 3'h5
// spacing minimums in link clock periods
`define DBS_T_RR 4'h4
`define DBS_T_RR_D 4'h4
`define DBS_T_PP 4'h4
`define DBS_T_PP_D 4'h1
`define DBS_T_WR 4'h6
`define DBS_T_WR_D 4'h2
// saturation value of the elapsed-slot counters
`define DBS_CNT_MAX 4'hf
// divider half period of the link clock in system clocks
`define DBS_HALF_DIV 4
`endif

// *** src/dbs_pkg.sv ***
// shared types of the bank-set link
package dbs_pkg;
   typedef logic [3:0] dbs_cnt_t;     // elapsed link slots, saturating
   typedef logic [2:0] dbs_op_t;      // command code
   typedef logic [5:0] dbs_data_t;    // data word
   typedef logic [11:0] dbs_req_t;    // request packet
   typedef enum logic [1:0] {
      dbs_st_idle,
      dbs_st_issued,
      dbs_st_ack
   } dbs_st_e;
endpackage

// *** src/dbs_link_if.sv ***
// link between memory controller and device: request pins, link clock, read return
`timescale 1ns/1ps
interface dbs_link_if;
   logic link_clk;                       // request_clock_pair, made by controller
   logic [11:0] request_bus_pins;        // request packet, changes on link clock fall
   logic [5:0] rd_data;                  // read data returned by device
   logic rd_toggle;                      // flips once per returned read
   modport ctrl (output link_clk, output request_bus_pins, input rd_data, input rd_toggle);
   modport dev (input link_clk, input request_bus_pins, output rd_data, output rd_toggle);
endinterface

// *** src/dbs_dev.sv ***
// device end: bank-set decode, internal set buses, spacing watchdog
`timescale 1ns/1ps
`include "dbs_defines.svh"
module dbs_dev
   import dbs_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   dbs_link_if.dev link,
   output logic spacing_err_o,
   output logic [7:0] row_open_o
);
   logic [2:0] clk_sync;                 // link clock: two sync stages plus edge history
   logic [11:0] req_s1, req_s2;          // request pins, two sync stages
   logic slot;                           // rising link edge seen
   dbs_data_t mem [8], next_mem [8];     // one word per bank
   dbs_data_t even_set_internal_bus, next_even_bus;
   dbs_data_t odd_set_internal_bus, next_odd_bus;
   logic [7:0] row_open, next_row_open;
   dbs_cnt_t since_act [2], next_since_act [2];
   dbs_cnt_t since_pre [2], next_since_pre [2];
   dbs_cnt_t since_wr [2], next_since_wr [2];
   dbs_data_t rd_data, next_rd_data;
   logic rd_toggle, next_rd_toggle;
   logic err, next_err;
   // each column word spends one clock on its set bus; this costs one clock of
   // read latency but keeps both internal buses on the real data path
   logic col_pend, next_col_pend;        // a column word waits on its set bus
   logic col_rd, next_col_rd;            // the waiting column is a read
   logic [2:0] col_bank, next_col_bank;  // bank of the waiting column
   dbs_data_t col_word;                  // word on the bus of the waiting column
   dbs_op_t op;
   logic [2:0] bank;
   logic set;

   assign slot = clk_sync[1] & ~clk_sync[2];
   assign op = req_s2[`DBS_OP_HI:`DBS_OP_LO];
   assign bank = req_s2[`DBS_BANK_HI:`DBS_BANK_LO];
   assign set = bank[0];                 // R1
   assign col_word = col_bank[0] ? odd_set_internal_bus : even_set_internal_bus; // R3
   assign link.rd_data = rd_data;
   assign link.rd_toggle = rd_toggle;
   assign spacing_err_o = err;
   assign row_open_o = row_open;

   // pin synchronisers; first stages feed only second stages
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         clk_sync <= 3'h0;
         req_s1 <= 12'h000;
         req_s2 <= 12'h000;
      end else begin
         clk_sync <= {clk_sync[1:0], link.link_clk};
         req_s1 <= link.request_bus_pins;
         req_s2 <= req_s1;
      end
   end

   // decode one packet per link edge; each set keeps its own counters and bus
   always_comb begin
      next_mem = mem;
      next_even_bus = even_set_internal_bus;
      next_odd_bus = odd_set_internal_bus;
      next_row_open = row_open;
      next_since_act = since_act;
      next_since_pre = since_pre;
      next_since_wr = since_wr;
      next_rd_data = rd_data;
      next_rd_toggle = rd_toggle;
      next_err = err;
      next_col_pend = 1'b0;
      next_col_rd = col_rd;
      next_col_bank = col_bank;
      // second clock of a column: the word moves off its set bus
      if (col_pend) begin
         if (col_rd) begin
            // transmit path takes the word from whichever set bus holds it
            next_rd_data = col_word; // R3
            next_rd_toggle = ~rd_toggle;
         end else begin
            // receive path lands the word from its set bus in the bank
            next_mem[col_bank] = col_word; // R3
         end
      end
      if (slot) begin
         for (int s = 0; s < 2; s++) begin // R2
            if (since_act[s] != `DBS_CNT_MAX) next_since_act[s] = since_act[s] + 4'h1;
            if (since_pre[s] != `DBS_CNT_MAX) next_since_pre[s] = since_pre[s] + 4'h1;
            if (since_wr[s] != `DBS_CNT_MAX) next_since_wr[s] = since_wr[s] + 4'h1;
         end
         case (op)
            `DBS_OP_ACT: begin
               // cross-set spacing equals same-set spacing here, no interleave
               if (since_act[set] < `DBS_T_RR || since_act[~set] < `DBS_T_RR_D)
                  next_err = 1'b1; // R9 R10
               next_row_open[bank] = 1'b1;
               next_since_act[set] = 4'h1;
            end
            `DBS_OP_PRE: begin
               // a lone precharge to the other set may sit between two
               if (since_pre[set] < `DBS_T_PP || since_pre[~set] < `DBS_T_PP_D)
                  next_err = 1'b1; // R13 R14
               next_row_open[bank] = 1'b0;
               next_since_pre[set] = 4'h1;
            end
            `DBS_OP_PRE_PAIR: begin
               // two precharges on one edge are not supported
               next_err = 1'b1; // R13
            end
            `DBS_OP_WR: begin
               // receive path drives whichever set bus owns the bank
               if (set) next_odd_bus = req_s2[`DBS_DATA_HI:`DBS_DATA_LO]; // R3
               else next_even_bus = req_s2[`DBS_DATA_HI:`DBS_DATA_LO];
               next_col_pend = 1'b1;
               next_col_rd = 1'b0;
               next_col_bank = bank;
               if (!row_open[bank]) next_err = 1'b1;
               next_since_wr[set] = 4'h1;
            end
            `DBS_OP_RD: begin
               // only the written set's bus needs the full turnaround
               if (since_wr[set] < `DBS_T_WR || since_wr[~set] < `DBS_T_WR_D)
                  next_err = 1'b1; // R6
               if (!row_open[bank]) next_err = 1'b1;
               if (set) next_odd_bus = mem[bank];
               else next_even_bus = mem[bank];
               next_col_pend = 1'b1;
               next_col_rd = 1'b1;
               next_col_bank = bank;
            end
            default: begin
               next_err = err;       // no-operation slot
            end
         endcase
      end
   end

   // state registers; counters start saturated so the first command is legal
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         for (int b = 0; b < 8; b++) mem[b] <= 6'h00;
         even_set_internal_bus <= 6'h00;
         odd_set_internal_bus <= 6'h00;
         row_open <= 8'h00;
         for (int s = 0; s < 2; s++) begin
            since_act[s] <= `DBS_CNT_MAX;
            since_pre[s] <= `DBS_CNT_MAX;
            since_wr[s] <= `DBS_CNT_MAX;
         end
         rd_data <= 6'h00;
         rd_toggle <= 1'b0;
         err <= 1'b0;
         col_pend <= 1'b0;
         col_rd <= 1'b0;
         col_bank <= 3'h0;
      end else begin
         mem <= next_mem;
         even_set_internal_bus <= next_even_bus;
         odd_set_internal_bus <= next_odd_bus;
         row_open <= next_row_open;
         since_act <= next_since_act;
         since_pre <= next_since_pre;
         since_wr <= next_since_wr;
         rd_data <= next_rd_data;
         rd_toggle <= next_rd_toggle;
         err <= next_err;
         col_pend <= next_col_pend;
         col_rd <= next_col_rd;
         col_bank <= next_col_bank;
      end
   end
endmodule

// *** src/dbs_ctrl.sv ***
// controller end: link clock divider and bank-set aware request scheduler
//
// Function
// R1 - bank set is lowest bank address bit
// R2 - even and odd sets decoded independently
// R3 - write and read reach either set bus
// R4 - keep write-to-read gap on same set
// R5 - shorter cross-set write-to-read gap allowed
// R6 - early reads only to opposite set
// R7 - space same-set activates by same-set minimum
// R8 - space cross-set activates by cross-set minimum
// R9 - cross-set activate minimum is four cycles
// R10 - equal minimums mean identical activate spacing
// R11 - space same-set precharges by same-set minimum
// R12 - space cross-set precharges by cross-set minimum
// R13 - no two precharges on one edge
// R14 - lone precharge may sit between two others
// R15 - track set history, pick matching minimum
`timescale 1ns/1ps
`include "dbs_defines.svh"
module dbs_ctrl
   import dbs_pkg::*;
#(
   parameter int HALF_DIV = `DBS_HALF_DIV
)
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic req_valid_i,
   input wire logic [2:0] req_op_i,
   input wire logic [2:0] req_bank_i,
   input wire logic [5:0] req_data_i,
   output logic req_ready_o,
   output logic rd_valid_o,
   output logic [5:0] rd_data_o,
   dbs_link_if.ctrl link
);
   // link clock divider
   logic [7:0] div_cnt, next_div_cnt;     // system clocks within a half period
   logic link_clk, next_link_clk;         // clock driven out to the device
   logic slot;                            // falling link edge: new packet goes out
   // scheduler state
   dbs_st_e state, next_state;
   dbs_req_t req_pins, next_req_pins;     // packet on the pins
   logic ready, next_ready;               // acceptance pulse to the user
   dbs_cnt_t since_act [2], next_since_act [2];
   dbs_cnt_t since_pre [2], next_since_pre [2];
   dbs_cnt_t since_wr [2], next_since_wr [2];
   logic set;                             // set of the waiting request
   logic legal;                           // waiting request may go in this slot
   // read return
   logic tog_s1, tog_s2, tog_s3;          // toggle sync stages and history
   logic [5:0] dat_s1, dat_s2;            // data sync stages
   logic rd_valid, next_rd_valid;
   logic [5:0] rd_data, next_rd_data;

   assign link.link_clk = link_clk;
   assign link.request_bus_pins = req_pins;
   assign req_ready_o = ready;
   assign rd_valid_o = rd_valid;
   assign rd_data_o = rd_data;
   assign slot = link_clk && (div_cnt == 8'(HALF_DIV - 1));
   assign set = req_bank_i[0]; // R1

   // spacing check: activate, precharge and read look at their own set and the other set
   always_comb begin
      case (req_op_i)
         `DBS_OP_ACT: begin
            // equal minimums give activates one common spacing, no interleave
            legal = (since_act[set] >= `DBS_T_RR) // R7 R10
               && (since_act[~set] >= `DBS_T_RR_D); // R8 R9
         end
         `DBS_OP_PRE: begin
            // cross-set minimum of one lets a precharge slip between two
            legal = (since_pre[set] >= `DBS_T_PP) // R11 R14
               && (since_pre[~set] >= `DBS_T_PP_D); // R12 R13
         end
         `DBS_OP_RD: begin
            // full turnaround only on the bus the write used
            legal = (since_wr[set] >= `DBS_T_WR) // R4
               && (since_wr[~set] >= `DBS_T_WR_D); // R5 R6
         end
         `DBS_OP_WR: begin
            legal = 1'b1;               // writes have no spacing here
         end
         default: begin
            // paired precharge and unknown codes are never sent
            legal = 1'b0; // R13
         end
      endcase
   end

   // divider: link period is twice HALF_DIV system clocks
   always_comb begin
      next_div_cnt = div_cnt + 8'h01;
      next_link_clk = link_clk;
      if (div_cnt == 8'(HALF_DIV - 1)) begin
         next_div_cnt = 8'h00;
         next_link_clk = ~link_clk;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         div_cnt <= 8'h00;
         link_clk <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         link_clk <= next_link_clk;
      end
   end

   // scheduler: one packet per link period, launched on the falling edge
   // so the pins are settled half a period before the device samples them
   always_comb begin
      next_state = state;
      next_req_pins = req_pins;
      next_ready = 1'b0;
      next_since_act = since_act;
      next_since_pre = since_pre;
      next_since_wr = since_wr;
      case (state)
         dbs_st_idle: begin
            if (slot) begin
               // every slot ages the history of both sets
               for (int s = 0; s < 2; s++) begin // R15
                  if (since_act[s] != `DBS_CNT_MAX) next_since_act[s] = since_act[s] + 4'h1;
                  if (since_pre[s] != `DBS_CNT_MAX) next_since_pre[s] = since_pre[s] + 4'h1;
                  if (since_wr[s] != `DBS_CNT_MAX) next_since_wr[s] = since_wr[s] + 4'h1;
               end
               next_req_pins = {`DBS_OP_NOP, 9'h000};
               if (req_valid_i && legal) begin
                  next_req_pins = {req_op_i, req_bank_i, req_data_i};
                  case (req_op_i)
                     `DBS_OP_ACT: next_since_act[set] = 4'h1; // R15
                     `DBS_OP_PRE: next_since_pre[set] = 4'h1; // R15
                     `DBS_OP_WR: next_since_wr[set] = 4'h1; // R15
                     default: next_since_wr = next_since_wr;
                  endcase
                  next_state = dbs_st_issued;
               end
            end
         end
         dbs_st_issued: begin
            // tell the user the request went out
            next_ready = 1'b1;
            next_state = dbs_st_ack;
         end
         dbs_st_ack: begin
            // one spare clock lets the user drop or change its request
            next_state = dbs_st_idle;
         end
         default: begin
            next_state = dbs_st_idle;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         state <= dbs_st_idle;
         req_pins <= 12'h000;
         ready <= 1'b0;
         for (int s = 0; s < 2; s++) begin
            since_act[s] <= `DBS_CNT_MAX;
            since_pre[s] <= `DBS_CNT_MAX;
            since_wr[s] <= `DBS_CNT_MAX;
         end
      end else begin
         state <= next_state;
         req_pins <= next_req_pins;
         ready <= next_ready;
         since_act <= next_since_act;
         since_pre <= next_since_pre;
         since_wr <= next_since_wr;
      end
   end

   // read return crosses from the device by toggle; data rides the same
   // two-stage delay and changes in the same device clock as the toggle
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         tog_s1 <= 1'b0;
         tog_s2 <= 1'b0;
         tog_s3 <= 1'b0;
         dat_s1 <= 6'h00;
         dat_s2 <= 6'h00;
      end else begin
         tog_s1 <= link.rd_toggle;
         tog_s2 <= tog_s1;
         tog_s3 <= tog_s2;
         dat_s1 <= link.rd_data;
         dat_s2 <= dat_s1;
      end
   end

   // one-cycle valid pulse per returned read
   always_comb begin
      next_rd_valid = tog_s2 ^ tog_s3;
      next_rd_data = rd_data;
      if (tog_s2 ^ tog_s3) next_rd_data = dat_s2;
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         rd_valid <= 1'b0;
         rd_data <= 6'h00;
      end else begin
         rd_valid <= next_rd_valid;
         rd_data <= next_rd_data;
      end
   end
endmodule

// *** tb/dbs_link_monitor.sv ***
// concurrent checks on the wire of the bank-set link
`timescale 1ns/1ps
`include "dbs_defines.svh"
module dbs_link_monitor #(
   parameter int HALF_DIV = 4
)
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic link_clk,
   input wire logic [11:0] request_bus_pins,
   input wire logic [5:0] rd_data,
   input wire logic rd_toggle
);
   logic link_q; // link clock one system clock ago
   logic slot; // a fresh packet stands on the pins
   logic [2:0] op; // command of the packet
   logic set; // bank set of the packet
   logic [3:0] hi_cnt; // high run of the link clock
   logic [3:0] next_hi;
   logic [3:0] act_c [2]; // link periods since last activate, per set
   logic [3:0] pre_c [2]; // same for precharge
   logic [3:0] wr_c [2]; // same for write
   logic [3:0] next_act [2];
   logic [3:0] next_pre [2];
   logic [3:0] next_wr [2];
   assign op = request_bus_pins[`DBS_OP_HI:`DBS_OP_LO];
   assign set = request_bus_pins[`DBS_BANK_LO];
   assign slot = link_q & ~link_clk;
   // saturating age: restart on a hit, count only on slots
   function automatic logic [3:0] age(input logic [3:0] c, input logic hit);
      return hit ? 4'h1 : (slot && c != `DBS_CNT_MAX) ? c + 4'h1 : c;
   endfunction
   // next values of the helper histories
   always_comb begin
      next_hi = link_clk ? hi_cnt + 4'h1 : 4'h0;
      for (int s = 0; s < 2; s++) begin
         next_act[s] = age(act_c[s], slot && op == `DBS_OP_ACT && set == 1'(s));
         next_pre[s] = age(pre_c[s], slot && op == `DBS_OP_PRE && set == 1'(s));
         next_wr[s] = age(wr_c[s], slot && op == `DBS_OP_WR && set == 1'(s));
      end
   end
   // histories start saturated so the first command is always legal
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         link_q <= 1'b0;
         hi_cnt <= 4'h0;
         act_c <= '{`DBS_CNT_MAX, `DBS_CNT_MAX};
         pre_c <= '{`DBS_CNT_MAX, `DBS_CNT_MAX};
         wr_c <= '{`DBS_CNT_MAX, `DBS_CNT_MAX};
      end else begin
         link_q <= link_clk;
         hi_cnt <= next_hi;
         act_c <= next_act;
         pre_c <= next_pre;
         wr_c <= next_wr;
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   property p_link_half;
      $fell(link_clk) |-> hi_cnt == HALF_DIV;
   endproperty
   property p_pins_fall;
      $changed(request_bus_pins) |-> slot;
   endproperty
   property p_op_legal;
      slot |-> op <= `DBS_OP_RD;
   endproperty
   property p_act_same;
      slot && op == `DBS_OP_ACT |-> act_c[set] >= `DBS_T_RR;
   endproperty
   property p_act_cross;
      slot && op == `DBS_OP_ACT |-> act_c[~set] >= `DBS_T_RR_D;
   endproperty
   property p_pre_same;
      slot && op == `DBS_OP_PRE |-> pre_c[set] >= `DBS_T_PP;
   endproperty
   property p_pre_cross;
      slot && op == `DBS_OP_PRE |-> pre_c[~set] >= `DBS_T_PP_D;
   endproperty
   property p_rd_same;
      slot && op == `DBS_OP_RD |-> wr_c[set] >= `DBS_T_WR;
   endproperty
   property p_rd_cross;
      slot && op == `DBS_OP_RD |-> wr_c[~set] >= `DBS_T_WR_D;
   endproperty
   a_link_half: assert property (p_link_half) else $error("link clock half period wrong");
   a_pins_fall: assert property (p_pins_fall) else $error("pins moved off link fall");
   a_op_legal: assert property (p_op_legal) else $error("unsupported command sent");
   a_act_same: assert property (p_act_same) else $error("same-set activates too close");
   a_act_cross: assert property (p_act_cross) else $error("cross activates too close");
   a_pre_same: assert property (p_pre_same) else $error("same-set precharges too close");
   a_pre_cross: assert property (p_pre_cross) else $error("cross precharges too close");
   a_rd_same: assert property (p_rd_same) else $error("read too soon after write");
   a_rd_cross: assert property (p_rd_cross) else $error("early read too soon");
   // main scenarios reached
   c_pre_cross: cover property (slot && op == `DBS_OP_PRE && pre_c[~set] == 4'h1);
   c_rd_cross: cover property (slot && op == `DBS_OP_RD && wr_c[~set] == 4'h2);
   c_act_cross: cover property (slot && op == `DBS_OP_ACT && act_c[~set] == 4'h4);
   c_rd_back: cover property ($changed(rd_toggle));
endmodule

// *** tb/tb_dram_bank_set_scheduling.sv ***
// self-checking bench: controller and device joined across the link
`timescale 1ns/1ps
`include "dbs_defines.svh"
module tb_dram_bank_set_scheduling;
   import dbs_pkg::*;
   localparam int SLOT = 2 * `DBS_HALF_DIV; // system clocks per link period
   logic clock_i;
   logic rst_n_i;
   logic req_valid_i;
   logic [2:0] req_op_i;
   logic [2:0] req_bank_i;
   logic [5:0] req_data_i;
   logic req_ready_o;
   logic rd_valid_o;
   logic [5:0] rd_data_o;
   logic spacing_err_o;
   logic err_b; // flag of the device on the faulty link
   logic [7:0] row_open_o;
   logic [7:0] row_open_b;
   int n_mismatch = 0;
   int n_tests = 0;
   int cyc = 0; // system clock count
   int t[6]; // ready times of a request series
   logic [5:0] rd_q[$]; // returned read words in order
   dbs_link_if link ();
   dbs_link_if link_b (); // bench drives this one badly on purpose
   dbs_ctrl #(.HALF_DIV(`DBS_HALF_DIV)) u_dbs_ctrl (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .req_valid_i(req_valid_i), .req_op_i(req_op_i), .req_bank_i(req_bank_i),
      .req_data_i(req_data_i), .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o),
      .rd_data_o(rd_data_o), .link(link.ctrl));
   dbs_dev u_dbs_dev (.clock_i(clock_i), .rst_n_i(rst_n_i), .link(link.dev),
      .spacing_err_o(spacing_err_o), .row_open_o(row_open_o));
   dbs_dev u_dbs_dev_b (.clock_i(clock_i), .rst_n_i(rst_n_i), .link(link_b.dev),
      .spacing_err_o(err_b), .row_open_o(row_open_b));
   dbs_link_monitor #(.HALF_DIV(`DBS_HALF_DIV)) u_dbs_link_monitor (.clock_i(clock_i),
      .rst_n_i(rst_n_i), .link_clk(link.link_clk), .request_bus_pins(link.request_bus_pins),
      .rd_data(link.rd_data), .rd_toggle(link.rd_toggle));
   initial begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end
   // count clocks and collect read returns, which stand one cycle
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (rd_valid_o === 1'b1) rd_q.push_back(rd_data_o);
   end
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // hold one request until ready; valid stays up so the next call chains
   task automatic req(input logic [2:0] op, input logic [2:0] bank, input logic [5:0] data,
      output int tr);
      int k;
      req_valid_i = 1'b1;
      req_op_i = op;
      req_bank_i = bank;
      req_data_i = data;
      for (k = 0; k < 40 * SLOT; k++) begin
         @(posedge clock_i);
         #1;
         if (req_ready_o === 1'b1) break;
      end
      // a request that never went out counts as a mismatch
      cmp({7'h00, req_ready_o}, 8'h01);
      tr = cyc;
   endtask
   task automatic idle(input int n);
      req_valid_i = 1'b0;
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   // one link period on the faulty link, pins change at the fall
   task automatic slot_b(input logic [2:0] op, input logic [2:0] bank);
      link_b.link_clk = 1'b0;
      link_b.request_bus_pins = {op, bank, 6'h00};
      #400;
      link_b.link_clk = 1'b1;
      #400;
   endtask
   task automatic end_of_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // watchdog, far beyond the few hundred clocks the tests need
   initial begin
      #(5000 * 100);
      n_mismatch++;
      end_of_test();
   end
   initial begin
      rst_n_i = 1'b0;
      req_valid_i = 1'b0;
      req_op_i = 3'h0;
      req_bank_i = 3'h0;
      req_data_i = 6'h00;
      link_b.link_clk = 1'b0;
      link_b.request_bus_pins = 12'h000;
      repeat (4) @(posedge clock_i);
      #1;
      rst_n_i = 1'b1;
      cmp(row_open_o, 8'h00);
      cmp({7'h00, spacing_err_o}, 8'h00);
      // activates across sets keep the same four-period spacing
      for (int b = 0; b < 4; b++) req(`DBS_OP_ACT, 3'(b), 6'h00, t[b]);
      cmp(8'(t[1] - t[0]), 8'(4 * SLOT));
      cmp(8'(t[2] - t[1]), 8'(4 * SLOT));
      cmp(8'(t[3] - t[2]), 8'(4 * SLOT));
      idle(3 * SLOT);
      cmp(row_open_o, 8'h0f);
      // writes to both sets, reads held back by the same-set gap
      req(`DBS_OP_WR, 3'h1, 6'h2a, t[0]);
      req(`DBS_OP_WR, 3'h0, 6'h15, t[1]);
      req(`DBS_OP_RD, 3'h1, 6'h00, t[2]);
      req(`DBS_OP_RD, 3'h0, 6'h00, t[3]);
      cmp(8'(t[1] - t[0]), 8'(SLOT));
      cmp(8'(t[2] - t[0]), 8'(6 * SLOT));
      cmp(8'(t[3] - t[1]), 8'(6 * SLOT));
      // early read to the opposite set of the last write
      req(`DBS_OP_WR, 3'h2, 6'h0c, t[4]);
      req(`DBS_OP_RD, 3'h1, 6'h00, t[5]);
      cmp(8'(t[5] - t[4]), 8'(2 * SLOT));
      idle(4 * SLOT);
      cmp(8'(rd_q.size()), 8'h03);
      cmp({2'b00, rd_q[0]}, 8'h2a);
      cmp({2'b00, rd_q[1]}, 8'h15);
      cmp({2'b00, rd_q[2]}, 8'h2a);
      // a lone precharge slots off-centre between two of the other set
      for (int b = 0; b < 4; b++) req(`DBS_OP_PRE, 3'(b), 6'h00, t[b]);
      cmp(8'(t[1] - t[0]), 8'(SLOT));
      cmp(8'(t[2] - t[1]), 8'(3 * SLOT));
      cmp(8'(t[3] - t[2]), 8'(SLOT));
      idle(3 * SLOT);
      cmp(row_open_o, 8'h00);
      cmp({7'h00, spacing_err_o}, 8'h00);
      // faulty link: legal cross activate, then one only a single period after it
      slot_b(`DBS_OP_NOP, 3'h0);
      slot_b(`DBS_OP_ACT, 3'h0);
      repeat (3) slot_b(`DBS_OP_NOP, 3'h0);
      slot_b(`DBS_OP_ACT, 3'h1);
      cmp({7'h00, err_b}, 8'h00);
      cmp(row_open_b, 8'h03);
      slot_b(`DBS_OP_ACT, 3'h2);
      slot_b(`DBS_OP_NOP, 3'h0);
      cmp({7'h00, err_b}, 8'h01);
      // reset in mid-run clears the sticky flag, then a paired precharge sets it
      rst_n_i = 1'b0;
      repeat (4) @(posedge clock_i);
      #1;
      rst_n_i = 1'b1;
      cmp({7'h00, err_b}, 8'h00);
      cmp(row_open_b, 8'h00);
      cmp({7'h00, spacing_err_o}, 8'h00);
      slot_b(`DBS_OP_PRE_PAIR, 3'h0);
      cmp({7'h00, err_b}, 8'h01);
      end_of_test();
   end
endmodule
